// ---- hdl/smg_pkg.sv ----
package smg_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SET_LATCH  = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH  = 8'h04;
    localparam logic [7:0] OP_STAT_READ  = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ   = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE  = 8'h02;
    localparam logic [7:0] OP_NV_SAVE    = 8'h3C;
    localparam logic [7:0] OP_NV_RESTORE = 8'h60;
    localparam logic [7:0] OP_ASAVE_ON   = 8'h59;
    localparam logic [7:0] OP_ASAVE_OFF  = 8'h19;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int         ADDR_W        = 17;
    localparam logic [4:0] LAST_OP_BIT   = 5'h07;
    localparam logic [4:0] LAST_HDR_BIT  = 5'h1F;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_TOP  = 17'h1FFFF;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h00000;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 17'h00001;

    // ------------------------------------------------------------
    // status byte fields and reset values
    // ------------------------------------------------------------
    localparam int         SR_BUSY_BIT  = 0;
    localparam int         SR_LATCH_BIT = 1;
    localparam int         SR_BG_LO_BIT = 2;
    localparam int         SR_BG_HI_BIT = 3;
    localparam int         SR_PGE_BIT   = 7;
    localparam logic       LATCH_RST    = 1'b0;
    localparam logic [1:0] BG_RST       = 2'h0;
    localparam logic       PGE_RST      = 1'b0;

    // ------------------------------------------------------------
    // block guard levels
    // ------------------------------------------------------------
    localparam logic [1:0] BG_NONE    = 2'h0;
    localparam logic [1:0] BG_QUARTER = 2'h1;
    localparam logic [1:0] BG_HALF    = 2'h2;
    localparam logic [1:0] BG_ALL     = 2'h3;

    // ------------------------------------------------------------
    // link-side frame phases
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_CMD  = 4'h1,
        PH_ADDR = 4'h2,
        PH_DATA = 4'h4,
        PH_SKIP = 4'h8
    } smg_phase_t;

endpackage

// ---- hdl/smg_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

// two-stage level synchroniser, one per bit
module smg_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // the first stage feeds the second stage only
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule

`default_nettype wire

// ---- hdl/smg_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module smg_top
(
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_reset,
    input  wire logic                      i_sck,
    input  wire logic                      i_cs_n,
    input  wire logic                      i_si,
    output logic                           o_so,
    output logic                           o_so_oe,
    input  wire logic                      i_guard_pin_n,
    input  wire logic                      i_nv_busy,
    output logic                           o_save_busy_pin_n,
    output logic                           o_write_latch,
    output logic                           o_block_guard_lo,
    output logic                           o_block_guard_hi,
    output logic                           o_pin_guard_enable,
    output logic                           o_status_busy,
    output logic                           o_save_start,
    output logic                           o_restore_start,
    output logic                           o_autosave_on,
    output logic                           o_autosave_off,
    output logic [smg_pkg::ADDR_W-1:0]     o_mem_rd_addr,
    input  wire logic [7:0]                i_mem_rd_data,
    output logic                           o_mem_wr_en,
    output logic [smg_pkg::ADDR_W-1:0]     o_mem_wr_addr,
    output logic [7:0]                     o_mem_wr_data
);
    import smg_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic addr_guarded(input logic [ADDR_W-1:0] a, input logic [1:0] bg);
        case (bg)
            BG_QUARTER: addr_guarded = (a[16:15] == 2'h3);
            BG_HALF:    addr_guarded = a[16];
            BG_ALL:     addr_guarded = 1'b1;
            default:    addr_guarded = 1'b0;
        endcase
    endfunction

    function automatic logic needs_latch(input logic [7:0] op);
        needs_latch = (op == OP_MEM_WRITE) || (op == OP_STAT_WRITE) || (op == OP_NV_SAVE)
                   || (op == OP_NV_RESTORE) || (op == OP_ASAVE_ON) || (op == OP_ASAVE_OFF);
    endfunction

    // ------------------------------------------------------------
    // link domain: declarations and crossings in
    // ------------------------------------------------------------
    smg_phase_t          phase_reg;
    logic [4:0]          bit_cnt_reg, to_link, at_link;
    logic [7:0]          shift_reg, op_reg, tx_reg, wr_data_reg;
    logic [7:0]          ev_reg, sr_data_reg, rx_byte, status_l;
    logic [ADDR_W-1:0]   addr_reg, wr_addr_reg;
    logic                so_en_reg, wr_en_reg, latch_l, pge_l, busy_l;
    logic [1:0]          bg_l;

    // status bits other than busy only change while select is high, so they are quasi-static at the link
    smg_sync #(.W(5)) u_sync_link (
        .i_clk   (i_sck),
        .i_reset (1'b0),
        .i_async (to_link),
        .o_sync  (at_link)
    );

    assign latch_l  = at_link[4];
    assign bg_l     = at_link[3:2];
    assign pge_l    = at_link[1];
    assign busy_l   = at_link[0];
    assign status_l = {pge_l, 3'h0, bg_l, latch_l, busy_l};
    assign rx_byte  = {shift_reg[6:0], i_si};

    // ------------------------------------------------------------
    // link domain: frame sequencer, sampled on rising sck
    // ------------------------------------------------------------
    // select high acts as the frame's own reset: the link clock may stop outside frames
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            phase_reg   <= PH_CMD;
            bit_cnt_reg <= 5'h00;
            shift_reg   <= 8'h00;
        end else begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            case (phase_reg)
                PH_CMD: begin
                    if (bit_cnt_reg == LAST_OP_BIT) begin
                        if ((rx_byte == OP_MEM_READ) && !busy_l) begin
                            phase_reg <= PH_ADDR;
                        end else if ((rx_byte == OP_MEM_WRITE) && latch_l && !busy_l) begin
                            phase_reg <= PH_ADDR;
                        end else if ((rx_byte == OP_STAT_WRITE) && latch_l) begin
                            phase_reg <= PH_DATA;
                        end else if (rx_byte == OP_STAT_READ) begin
                            phase_reg <= PH_DATA;
                        end else begin
                            phase_reg <= PH_SKIP;
                        end
                    end
                end
                PH_ADDR: begin
                    if (bit_cnt_reg == LAST_HDR_BIT) begin
                        phase_reg <= PH_DATA;
                    end
                end
                PH_DATA: begin
                    // a status write takes exactly one byte
                    if ((op_reg == OP_STAT_WRITE) && (bit_cnt_reg[2:0] == LAST_DATA_BIT)) begin
                        phase_reg <= PH_SKIP;
                    end
                end
                default: begin
                    phase_reg <= PH_SKIP;
                end
            endcase
        end
    end

    // opcode and burst address
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            op_reg   <= 8'h00;
            addr_reg <= ADDR_ZERO;
        end else begin
            if ((phase_reg == PH_CMD) && (bit_cnt_reg == LAST_OP_BIT)) begin
                op_reg <= rx_byte;
            end
            // upper seven bits of the first address byte fall off the top
            if (phase_reg == PH_ADDR) begin
                addr_reg <= {addr_reg[ADDR_W-2:0], i_si};
            end else if ((phase_reg == PH_DATA) && (bit_cnt_reg[2:0] == LAST_DATA_BIT)
                         && (op_reg != OP_STAT_WRITE)) begin
                addr_reg <= (addr_reg == ADDR_TOP) ? ADDR_ZERO : addr_reg + ADDR_ONE;
            end
        end
    end

    // memory write strobe: discarded inside the guarded range, address still advances
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            wr_en_reg   <= 1'b0;
            wr_addr_reg <= ADDR_ZERO;
            wr_data_reg <= 8'h00;
        end else if ((phase_reg == PH_DATA) && (op_reg == OP_MEM_WRITE)
                     && (bit_cnt_reg[2:0] == LAST_DATA_BIT)) begin
            wr_en_reg   <= !addr_guarded(addr_reg, bg_l);
            wr_addr_reg <= addr_reg;
            wr_data_reg <= rx_byte;
        end else begin
            wr_en_reg   <= 1'b0;
        end
    end

    // frame events; cleared on the first edge of a frame and held past select rising
    always_ff @(posedge i_sck) begin
        if ((phase_reg == PH_CMD) && (bit_cnt_reg == 5'h00)) begin
            ev_reg      <= 8'h00;
        end else if ((phase_reg == PH_CMD) && (bit_cnt_reg == LAST_OP_BIT)) begin
            ev_reg[7] <= (rx_byte == OP_SET_LATCH);
            ev_reg[6] <= (rx_byte == OP_CLR_LATCH);
            ev_reg[5] <= latch_l && needs_latch(rx_byte)
                         && !((rx_byte == OP_MEM_WRITE) && busy_l);
            ev_reg[3] <= latch_l && (rx_byte == OP_NV_SAVE);
            ev_reg[2] <= latch_l && (rx_byte == OP_NV_RESTORE);
            ev_reg[1] <= latch_l && (rx_byte == OP_ASAVE_ON);
            ev_reg[0] <= latch_l && (rx_byte == OP_ASAVE_OFF);
        end else if ((phase_reg == PH_DATA) && (op_reg == OP_STAT_WRITE)
                     && (bit_cnt_reg[2:0] == LAST_DATA_BIT)) begin
            ev_reg[4]   <= 1'b1;
            sr_data_reg <= rx_byte;
        end
    end

    // ------------------------------------------------------------
    // link domain: output shifter on falling sck
    // ------------------------------------------------------------
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            tx_reg    <= 8'h00;
            so_en_reg <= 1'b0;
        end else begin
            so_en_reg <= (phase_reg == PH_DATA)
                         && ((op_reg == OP_MEM_READ) || (op_reg == OP_STAT_READ));
            if ((phase_reg == PH_DATA) && (bit_cnt_reg[2:0] == 3'h0)) begin
                tx_reg <= (op_reg == OP_MEM_READ) ? i_mem_rd_data : status_l;
            end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    assign o_so          = tx_reg[7];
    assign o_so_oe       = so_en_reg;
    assign o_mem_rd_addr = addr_reg;
    assign o_mem_wr_en   = wr_en_reg;
    assign o_mem_wr_addr = wr_addr_reg;
    assign o_mem_wr_data = wr_data_reg;

    // ------------------------------------------------------------
    // system domain: crossings in
    // ------------------------------------------------------------
    logic [1:0]  pins_s;
    logic [15:0] ev_s;
    logic        cs_n_s, guard_pin_n_s, cs_q_reg, cs_rise, cs_fall;
    logic        pin_low_reg, latch_reg, pge_reg, busy_pin_n_reg;
    logic [1:0]  bg_reg;
    logic [3:0]  nv_pulse_reg;

    // lanes carry active levels so the cleared stages read as idle: no false select edge after reset
    smg_sync #(.W(2)) u_sync_pins (
        .i_clk   (i_sys_clk),
        .i_reset (i_reset),
        .i_async ({!i_cs_n, !i_guard_pin_n}),
        .o_sync  (pins_s)
    );

    // events are stable long before select rises, so plain level sync is enough
    smg_sync #(.W(16)) u_sync_ev (
        .i_clk   (i_sys_clk),
        .i_reset (i_reset),
        .i_async ({ev_reg, sr_data_reg}),
        .o_sync  (ev_s)
    );

    assign cs_n_s        = !pins_s[1];
    assign guard_pin_n_s = !pins_s[0];
    assign cs_rise       = cs_n_s && !cs_q_reg;
    assign cs_fall       = !cs_n_s && cs_q_reg;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cs_q_reg    <= 1'b1;
            pin_low_reg <= 1'b0;
        end else begin
            cs_q_reg <= cs_n_s;
            // pin level frozen at frame start so a late fall spares the write
            if (cs_fall) begin
                pin_low_reg <= !guard_pin_n_s;
            end
        end
    end

    // ------------------------------------------------------------
    // system domain: write latch and status bits
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            latch_reg <= LATCH_RST;
        end else if (cs_rise) begin
            if (ev_s[15]) begin
                latch_reg <= 1'b1;
            end else if (ev_s[14] || ev_s[13]) begin
                latch_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            bg_reg  <= BG_RST;
            pge_reg <= PGE_RST;
        end else if (cs_rise && ev_s[12] && !(pge_reg && pin_low_reg)) begin
            bg_reg  <= {ev_s[SR_BG_HI_BIT], ev_s[SR_BG_LO_BIT]};
            pge_reg <= ev_s[SR_PGE_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            nv_pulse_reg   <= 4'h0;
            busy_pin_n_reg <= 1'b1;
        end else begin
            nv_pulse_reg   <= cs_rise ? ev_s[11:8] : 4'h0;
            busy_pin_n_reg <= !i_nv_busy;
        end
    end

    assign to_link            = {latch_reg, bg_reg, pge_reg, i_nv_busy};
    assign o_write_latch      = latch_reg;
    assign o_block_guard_lo   = bg_reg[0];
    assign o_block_guard_hi   = bg_reg[1];
    assign o_pin_guard_enable = pge_reg;
    assign o_status_busy      = !busy_pin_n_reg;
    assign o_save_busy_pin_n  = busy_pin_n_reg;
    assign o_save_start       = nv_pulse_reg[3];
    assign o_restore_start    = nv_pulse_reg[2];
    assign o_autosave_on      = nv_pulse_reg[1];
    assign o_autosave_off     = nv_pulse_reg[0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_frame_end;
        cs_rise;
    endsequence
    sequence s_latch_set_frame;
        s_frame_end ##0 ev_s[15];
    endsequence
    sequence s_latch_drop_frame;
        s_frame_end ##0 (ev_s[14] || ev_s[13]) && !ev_s[15];
    endsequence

    chk_latch_powerup: assert property (@(posedge i_sys_clk)
        i_reset |=> !o_write_latch) else $error("write latch not clear after reset");
    chk_latch_set_cmd: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        s_latch_set_frame |=> o_write_latch) else $error("set-latch command did not set latch");
    chk_latch_auto_clear: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        s_latch_drop_frame |=> !o_write_latch) else $error("latch not cleared at end of frame");
    chk_latch_only_at_end: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !cs_rise |=> $stable(o_write_latch)) else $error("latch changed outside select rising");
    chk_status_pin_block: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (s_frame_end ##0 ev_s[12] && pge_reg && pin_low_reg) |=> $stable(bg_reg) && pge_reg)
        else $error("status write accepted with guard pin low");
    chk_status_pin_free: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (s_frame_end ##0 ev_s[12] && !pge_reg) |=> bg_reg == $past(ev_s[3:2]))
        else $error("status write lost with guard disabled");
    chk_pin_frozen: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !cs_fall |=> $stable(pin_low_reg)) else $error("guard pin level changed mid frame");
    chk_busy_pin_flag: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_nv_busy |=> o_status_busy && !o_save_busy_pin_n) else $error("busy not reported");
    chk_read_refused: assert property (@(posedge i_sck) disable iff (i_cs_n)
        (phase_reg == PH_CMD) && (bit_cnt_reg == LAST_OP_BIT) && busy_l |=> phase_reg != PH_ADDR)
        else $error("memory access taken while busy");
    chk_guarded_drop: assert property (@(posedge i_sck) disable iff (i_cs_n)
        wr_en_reg |-> !addr_guarded(wr_addr_reg, bg_l)) else $error("write strobe inside guarded range");
    chk_addr_wrap: assert property (@(posedge i_sck) disable iff (i_cs_n)
        (phase_reg == PH_DATA) && (op_reg == OP_MEM_READ) && (bit_cnt_reg[2:0] == LAST_DATA_BIT)
        && (addr_reg == ADDR_TOP) |=> addr_reg == ADDR_ZERO)
        else $error("burst address did not wrap");
    chk_ignored_no_write: assert property (@(posedge i_sck) disable iff (i_cs_n)
        (phase_reg == PH_CMD) && (bit_cnt_reg == LAST_OP_BIT) && !latch_l |=> ##1 !wr_en_reg [*8])
        else $error("write while latch clear");

endmodule

`default_nettype wire

// ---- tb/smg_host.sv ----
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// spi mode 0 host, clock stands low outside frames
// ------------------------------------------------------------
module smg_host (
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_si,
    input  wire logic i_so
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end

    task automatic start();
        o_cs_n = 1'b0;
        #3;
    endtask

    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_si = tx[i];
            #3;
            o_sck = 1'b1;
            rx[i] = i_so;
            #3;
            o_sck = 1'b0;
        end
    endtask

    task automatic stop();
        #3;
        o_cs_n = 1'b1;
        // released line must not keep its last level
        o_si = ~o_si;
        #100;
    endtask
endmodule

`default_nettype wire

// ---- tb/test_smg_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module test_smg_top;
    import smg_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        rst, sck, cs_n, si, so, so_oe, guard_n, nv_busy, busy_n, latch;
    logic        bg_lo, bg_hi, pge, sbusy, sv, rs, aon, aoff, wr_en;
    logic [16:0] rd_addr, wr_addr;
    logic [7:0]  rd_data, wr_data, b0, b1, o0, o1, d;
    logic [7:0]  mem [0:17'h1FFFF];
    logic [16:0] a;
    logic [7:0]  nv_ops [4] = '{OP_NV_SAVE, OP_NV_RESTORE, OP_ASAVE_ON, OP_ASAVE_OFF};
    int          error_cnt = 0;
    int          num_checks = 0;
    int          pulses = 0;
    logic [3:0]  seen = 4'h0;

    always #5 i_sys_clk = ~i_sys_clk;

    smg_host host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));

    smg_top uut (.i_sys_clk(i_sys_clk), .i_reset(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so),
        .o_so_oe(so_oe), .i_guard_pin_n(guard_n), .i_nv_busy(nv_busy), .o_save_busy_pin_n(busy_n),
        .o_write_latch(latch), .o_block_guard_lo(bg_lo), .o_block_guard_hi(bg_hi),
        .o_pin_guard_enable(pge), .o_status_busy(sbusy), .o_save_start(sv), .o_restore_start(rs),
        .o_autosave_on(aon), .o_autosave_off(aoff), .o_mem_rd_addr(rd_addr), .i_mem_rd_data(rd_data),
        .o_mem_wr_en(wr_en), .o_mem_wr_addr(wr_addr), .o_mem_wr_data(wr_data));

    // ------------------------------------------------------------
    // external memory: combinational read, capture on falling sck
    // ------------------------------------------------------------
    assign rd_data = mem[rd_addr];
    always @(negedge sck) if (wr_en === 1'b1) mem[wr_addr] <= wr_data;
    // pulses are launched on the rising edge, so look at them on the falling one
    always @(negedge i_sys_clk) begin
        if ((sv | rs | aon | aoff) === 1'b1) begin
            pulses++;
            seen = {sv, rs, aon, aoff};
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmd1(input logic [7:0] op);
        logic [7:0] rx;
        host.start();
        host.xbyte(op, rx);
        host.stop();
    endtask

    task automatic hdr(input logic [7:0] op, input logic [16:0] ad);
        logic [7:0] rx;
        host.start();
        host.xbyte(op, rx);
        host.xbyte({7'h00, ad[16]}, rx);
        host.xbyte(ad[15:8], rx);
        host.xbyte(ad[7:0], rx);
    endtask

    // two-byte burst write, optionally armed first
    task automatic wr2(input logic [16:0] ad, input logic [7:0] dv, input logic arm);
        logic [7:0] rx;
        if (arm) cmd1(OP_SET_LATCH);
        hdr(OP_MEM_WRITE, ad);
        host.xbyte(dv, rx);
        host.xbyte(dv + 8'h01, rx);
        host.stop();
    endtask

    task automatic rd2(input logic [16:0] ad, output logic [7:0] r0, output logic [7:0] r1);
        hdr(OP_MEM_READ, ad);
        host.xbyte(8'h00, r0);
        host.xbyte(8'h00, r1);
        host.stop();
    endtask

    task automatic swr(input logic [7:0] v);
        logic [7:0] rx;
        cmd1(OP_SET_LATCH);
        host.start();
        host.xbyte(OP_STAT_WRITE, rx);
        host.xbyte(v, rx);
        host.stop();
    endtask

    task automatic guard(input logic v);
        @(negedge i_sys_clk);
        guard_n = v;
        repeat (4) @(negedge i_sys_clk);
    endtask

    function automatic logic prot(input logic [1:0] l, input logic [16:0] ad);
        return (l == BG_ALL) || (l == BG_HALF && ad[16]) || (l == BG_QUARTER && ad[16:15] == 2'h3);
    endfunction

    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        guard_n = 1'b1;
        nv_busy = 1'b0;
        for (int i = 0; i < 131072; i++) mem[i] = 8'hA5;
        repeat (2) @(negedge i_sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk(latch, 17'h0);
        wr2(17'h00010, 8'h11, 1'b0);
        rd2(17'h00010, b0, b1);
        chk({b1, b0}, 17'hA5A5);
        cmd1(OP_SET_LATCH);
        chk(latch, 17'h1);
        cmd1(OP_CLR_LATCH);
        chk(latch, 17'h0);
        wr2(ADDR_TOP, 8'h21, 1'b1);
        chk(latch, 17'h0);
        rd2(ADDR_TOP, b0, b1);
        chk({b0, b1}, 17'h2122);
        swr(8'hFC);
        srd_blk : begin
            host.start();
            host.xbyte(OP_STAT_READ, b0);
            host.xbyte(8'h00, b0);
            host.stop();
        end
        chk(b0, 17'h8C);
        guard(1'b0);
        swr(8'h00);
        chk({pge, bg_hi, bg_lo}, 17'h7);
        guard(1'b1);
        cmd1(OP_SET_LATCH);
        host.start();
        host.xbyte(OP_STAT_WRITE, b0);
        guard(1'b0);
        host.xbyte(8'h84, b0);
        host.stop();
        chk({pge, bg_hi, bg_lo}, 17'h5);
        guard(1'b1);
        swr(8'h04);
        guard(1'b0);
        swr(8'h08);
        chk({pge, bg_hi, bg_lo}, 17'h2);
        guard(1'b1);
        for (int l = 0; l < 4; l++) begin
            swr({4'h0, l[1:0], 2'h0});
            for (int k = 0; k < 2; k++) begin
                a = k ? ADDR_TOP : 17'h0FFFF;
                d = {2'h0, l[1:0], 4'h8};
                o0 = mem[a];
                o1 = mem[a + ADDR_ONE];
                wr2(a, d, 1'b1);
                chk(mem[a], prot(l[1:0], a) ? o0 : d);
                chk(mem[a + ADDR_ONE], prot(l[1:0], a + ADDR_ONE) ? o1 : d + 8'h01);
            end
        end
        swr(8'h00);
        for (int k = 0; k < 4; k++) begin
            cmd1(OP_SET_LATCH);
            cmd1(nv_ops[k]);
            chk({latch, pulses[15:0]}, 17'(k + 1));
            chk(17'(seen), 17'(4'h8 >> k));
        end
        cmd1(OP_NV_SAVE);
        chk(pulses[16:0], 17'h4);
        @(negedge i_sys_clk);
        nv_busy = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        chk({sbusy, busy_n}, 17'h2);
        hdr(OP_MEM_READ, 17'h00000);
        host.xbyte(8'h00, b0);
        chk(so_oe, 17'h0);
        host.stop();
        wr2(17'h00020, 8'h77, 1'b1);
        chk(mem[17'h00020], 17'hA5);
        @(negedge i_sys_clk);
        nv_busy = 1'b0;
        report_and_stop();
    end
endmodule

`default_nettype wire
